/* File: atq_pkg.sv */
// atq_pkg: constants, enums and the configuration carrier for the trigger qualifier.
// assumes a 32-bit avalon-mm slave with byte addresses and one sample clock.
package atq_pkg;
    // widths
    localparam int SW   = 16;   // sample and level width
    localparam int TW   = 24;   // time counts, in sample-strobe or external timebase ticks
    localparam int CW   = 16;   // event counter width
    localparam int HIST = 16;   // deepest slope window, in samples
    localparam int AW   = 6;    // byte address width

    // register byte offsets
    localparam logic [AW-1:0] OFS_CTRL   = 6'h00;
    localparam logic [AW-1:0] OFS_PRIM   = 6'h04;
    localparam logic [AW-1:0] OFS_SEC    = 6'h08;
    localparam logic [AW-1:0] OFS_HYST   = 6'h0c;
    localparam logic [AW-1:0] OFS_WIN    = 6'h10;
    localparam logic [AW-1:0] OFS_PWIDTH = 6'h14;
    localparam logic [AW-1:0] OFS_HOLD   = 6'h18;
    localparam logic [AW-1:0] OFS_TSTART = 6'h1c;
    localparam logic [AW-1:0] OFS_TWIDTH = 6'h20;
    localparam logic [AW-1:0] OFS_PRESET = 6'h24;
    localparam logic [AW-1:0] OFS_STATUS = 6'h28;

    // control register fields
    localparam int CTRL_CHAN  = 0;  // 2 bits
    localparam int CTRL_MODE  = 2;  // 3 bits
    localparam int CTRL_DIR   = 5;  // 1 = falling
    localparam int CTRL_SLOPE = 6;
    localparam int CTRL_PULSE = 7;  // 2 bits
    localparam int CTRL_TIMER = 9;  // 3 bits
    localparam int CTRL_MARK  = 12; // 3 bits
    localparam int CTRL_EXTTB = 15;

    // status register fields
    localparam int STAT_CNT  = 0;   // 16 bits
    localparam int STAT_HOLD = 16;
    localparam int STAT_SEEN = 17;

    // reset values
    localparam logic [4:0]    WIN_RST    = 5'h01;
    localparam logic [CW-1:0] PRESET_RST = 16'h0001;

    typedef enum logic [1:0] {
        CHAN_ANALOG = 2'b00,
        CHAN_MARKER = 2'b01,
        CHAN_BUS    = 2'b10,
        CHAN_CALC   = 2'b11
    } atq_chan_e;

    typedef enum logic [2:0] {
        MODE_OFF        = 3'b000,
        MODE_BASIC      = 3'b001,
        MODE_DUAL       = 3'b010,
        MODE_BASIC_QUAL = 3'b011,
        MODE_DUAL_QUAL  = 3'b100
    } atq_mode_e;

    typedef enum logic [1:0] {
        PULSE_OFF    = 2'b00,
        PULSE_DETECT = 2'b01,
        PULSE_REJECT = 2'b10
    } atq_pulse_e;

    typedef enum logic [2:0] {
        TIMER_DIS          = 3'b000,
        TIMER_LESS         = 3'b001,
        TIMER_MORE         = 3'b010,
        TIMER_BETWEEN      = 3'b011,
        outside_range_mode = 3'b100
    } atq_timer_e;

    typedef enum logic [2:0] {
        MARK_OFF   = 3'b000,
        MARK_RISE  = 3'b001,
        MARK_FALL  = 3'b010,
        MARK_QHIGH = 3'b011,
        MARK_QLOW  = 3'b100
    } atq_mark_e;

    // whole configuration as written by software
    typedef struct packed {
        atq_chan_e          chan;
        atq_mode_e          mode;
        logic               dir_fall;
        logic               slope_trigger_enable;
        atq_pulse_e         pulse;
        atq_timer_e         timer;
        atq_mark_e          mark;
        logic               ext_tb;
        logic signed [SW-1:0] prim;
        logic signed [SW-1:0] sec;
        logic [SW-1:0]      hyst;
        logic [4:0]         win;
        logic [TW-1:0]      pwidth;
        logic [TW-1:0]      hold;
        logic [TW-1:0]      tstart;
        logic [TW-1:0]      twidth;
        logic [CW-1:0]      preset;
    } atq_cfg_s;
endpackage : atq_pkg

/* File: atq_trigger.sv */
// atq_trigger: per-channel digital trigger detector with qualifiers.
// assumes samples arrive on clock_i with a valid strobe; marker, qualifier and
// external timebase tick are asynchronous pins.
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns

// single-level crossing detector with hysteresis zone
module atq_level_det (
    // clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       srst_i,
    // sample side
    input  wire logic                       en_i,
    input  wire logic signed [atq_pkg::SW:0] x_i,
    input  wire logic signed [atq_pkg::SW-1:0] lvl_i,
    input  wire logic [atq_pkg::SW-1:0]     hyst_i,
    input  wire logic                       fall_i,
    // results
    output logic                            fire_o,
    output logic                            beyond_o
);
    logic                        armed;
    logic signed [atq_pkg::SW+1:0] lo;
    logic signed [atq_pkg::SW+1:0] hi;
    logic signed [atq_pkg::SW+1:0] xv;
    logic signed [atq_pkg::SW+1:0] lv;

    // hysteresis zone around the level
    assign lv = {{2{lvl_i[atq_pkg::SW-1]}}, lvl_i};
    assign xv = {x_i[atq_pkg::SW], x_i};
    assign lo = lv - {2'b00, hyst_i};
    assign hi = lv + {2'b00, hyst_i};
    // strictly past the level, equality never counts
    assign beyond_o = fall_i ? (xv < lv) : (xv > lv);

    // arm on leaving the far side of the zone, fire on passing the level
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            armed  <= 1'b0;
            fire_o <= 1'b0;
        end else begin
            fire_o <= 1'b0;
            if (en_i) begin
                if (armed && beyond_o) begin
                    fire_o <= 1'b1;
                    armed  <= 1'b0;
                end else if (fall_i ? (xv > hi) : (xv < lo)) begin
                    armed <= 1'b1;
                end
            end
        end
    end
endmodule : atq_level_det

module atq_trigger (
    // clock and reset
    input  wire logic                         clock_i,
    input  wire logic                         srst_i,
    // avalon-mm slave
    input  wire logic [atq_pkg::AW-1:0]       avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    // sample stream
    input  wire logic                         sample_valid_i,
    input  wire logic signed [atq_pkg::SW-1:0] sample_i,
    // asynchronous pins
    input  wire logic                         marker_i,
    input  wire logic                         qualifier_i,
    input  wire logic                         ext_tick_i,
    // trigger result
    output logic                              trig_o
);
    atq_pkg::atq_cfg_s          cfg;
    logic [2:0]                 sync1, sync2, sync3, pin_lvl;
    logic                       tick_prev, mark_prev;
    logic                       time_tick;
    logic signed [atq_pkg::SW-1:0] hist [atq_pkg::HIST];
    logic [3:0]                 win_idx;
    logic signed [atq_pkg::SW:0] x;
    logic                       p_fire, p_beyond, s_fire, s_beyond;
    logic                       run;
    logic [atq_pkg::TW-1:0]     pcnt;
    logic                       p_evt;
    logic                       det_evt, qual_mode, raw_evt, pass_evt;
    logic [atq_pkg::TW-1:0]     hold_cnt;
    logic [atq_pkg::TW-1:0]     itv_cnt;
    logic [atq_pkg::TW:0]       win_end;
    logic                       seen;
    logic [atq_pkg::CW-1:0]     evt_cnt;
    logic [atq_pkg::CW-1:0]     next_evt_cnt;
    logic                       final_trig;
    logic                       wr_ok;
    logic [31:0]                rd_mux;

    // bus: one wait cycle, then the request is taken at the edge waitrequest is low
    assign wr_ok = avs_write && !avs_waitrequest;
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    // configuration writes; unmapped and status offsets ignore writes
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cfg        <= '0;
            cfg.win    <= atq_pkg::WIN_RST;
            cfg.preset <= atq_pkg::PRESET_RST;
        end else if (wr_ok) begin
            case (avs_address)
                atq_pkg::OFS_CTRL: begin
                    cfg.chan  <= atq_pkg::atq_chan_e'(avs_writedata[atq_pkg::CTRL_CHAN +: 2]);
                    cfg.mode  <= atq_pkg::atq_mode_e'(avs_writedata[atq_pkg::CTRL_MODE +: 3]);
                    cfg.dir_fall             <= avs_writedata[atq_pkg::CTRL_DIR];
                    cfg.slope_trigger_enable <= avs_writedata[atq_pkg::CTRL_SLOPE];
                    cfg.pulse <= atq_pkg::atq_pulse_e'(avs_writedata[atq_pkg::CTRL_PULSE +: 2]);
                    cfg.timer <= atq_pkg::atq_timer_e'(avs_writedata[atq_pkg::CTRL_TIMER +: 3]);
                    cfg.mark  <= atq_pkg::atq_mark_e'(avs_writedata[atq_pkg::CTRL_MARK +: 3]);
                    cfg.ext_tb <= avs_writedata[atq_pkg::CTRL_EXTTB];
                end
                atq_pkg::OFS_PRIM:   cfg.prim   <= avs_writedata[atq_pkg::SW-1:0];
                atq_pkg::OFS_SEC:    cfg.sec    <= avs_writedata[atq_pkg::SW-1:0];
                atq_pkg::OFS_HYST:   cfg.hyst   <= avs_writedata[atq_pkg::SW-1:0];
                atq_pkg::OFS_WIN:    cfg.win    <= avs_writedata[4:0];
                atq_pkg::OFS_PWIDTH: cfg.pwidth <= avs_writedata[atq_pkg::TW-1:0];
                atq_pkg::OFS_HOLD:   cfg.hold   <= avs_writedata[atq_pkg::TW-1:0];
                atq_pkg::OFS_TSTART: cfg.tstart <= avs_writedata[atq_pkg::TW-1:0];
                atq_pkg::OFS_TWIDTH: cfg.twidth <= avs_writedata[atq_pkg::TW-1:0];
                atq_pkg::OFS_PRESET: cfg.preset <= avs_writedata[atq_pkg::CW-1:0];
                default: ;
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0;
        case (avs_address)
            atq_pkg::OFS_CTRL: begin
                rd_mux[atq_pkg::CTRL_CHAN +: 2]  = cfg.chan;
                rd_mux[atq_pkg::CTRL_MODE +: 3]  = cfg.mode;
                rd_mux[atq_pkg::CTRL_DIR]        = cfg.dir_fall;
                rd_mux[atq_pkg::CTRL_SLOPE]      = cfg.slope_trigger_enable;
                rd_mux[atq_pkg::CTRL_PULSE +: 2] = cfg.pulse;
                rd_mux[atq_pkg::CTRL_TIMER +: 3] = cfg.timer;
                rd_mux[atq_pkg::CTRL_MARK +: 3]  = cfg.mark;
                rd_mux[atq_pkg::CTRL_EXTTB]      = cfg.ext_tb;
            end
            atq_pkg::OFS_PRIM:   rd_mux[atq_pkg::SW-1:0] = cfg.prim;
            atq_pkg::OFS_SEC:    rd_mux[atq_pkg::SW-1:0] = cfg.sec;
            atq_pkg::OFS_HYST:   rd_mux[atq_pkg::SW-1:0] = cfg.hyst;
            atq_pkg::OFS_WIN:    rd_mux[4:0] = cfg.win;
            atq_pkg::OFS_PWIDTH: rd_mux[atq_pkg::TW-1:0] = cfg.pwidth;
            atq_pkg::OFS_HOLD:   rd_mux[atq_pkg::TW-1:0] = cfg.hold;
            atq_pkg::OFS_TSTART: rd_mux[atq_pkg::TW-1:0] = cfg.tstart;
            atq_pkg::OFS_TWIDTH: rd_mux[atq_pkg::TW-1:0] = cfg.twidth;
            atq_pkg::OFS_PRESET: rd_mux[atq_pkg::CW-1:0] = cfg.preset;
            atq_pkg::OFS_STATUS: begin
                rd_mux[atq_pkg::STAT_CNT +: atq_pkg::CW] = evt_cnt;
                rd_mux[atq_pkg::STAT_HOLD] = (hold_cnt != '0);
                rd_mux[atq_pkg::STAT_SEEN] = seen;
            end
            default: rd_mux = 32'h0;
        endcase
    end

    // read data stands at the edge where waitrequest is sampled low
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rd_mux;
        end
    end

    // pin synchronisers; a level only moves when stages two and three agree
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sync1   <= 3'h0;
            sync2   <= 3'h0;
            sync3   <= 3'h0;
            pin_lvl <= 3'h0;
        end else begin
            sync1 <= {ext_tick_i, qualifier_i, marker_i};
            sync2 <= sync1;
            sync3 <= sync2;
            for (int i = 0; i < 3; i++) begin
                if (sync2[i] == sync3[i]) pin_lvl[i] <= sync3[i];
            end
        end
    end

    // time base: sample ticks, or external ticks when that timebase is chosen
    always_ff @(posedge clock_i) begin
        if (srst_i) tick_prev <= 1'b0;
        else        tick_prev <= pin_lvl[2];
    end
    assign time_tick = cfg.ext_tb ? (pin_lvl[2] && !tick_prev) : sample_valid_i;

    // sample history for the slope window
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            for (int i = 0; i < atq_pkg::HIST; i++) hist[i] <= '0;
        end else if (sample_valid_i) begin
            hist[0] <= sample_i;
            for (int i = 1; i < atq_pkg::HIST; i++) hist[i] <= hist[i-1];
        end
    end

    // window clamped to 1..HIST samples back; zero treated as one
    assign win_idx = (cfg.win == 5'h00) ? 4'h0 :
                     (cfg.win > 5'h10)  ? 4'hf : 4'(cfg.win - 5'h01);
    // difference ends on the current sample, so a hit lands on the window's last sample
    assign x = cfg.slope_trigger_enable
             ? (17'(sample_i) - 17'(hist[win_idx]))
             : 17'(sample_i);

    // primary and secondary detectors, secondary in the opposite direction
    atq_level_det u_prim (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .en_i     (sample_valid_i),
        .x_i      (x),
        .lvl_i    (cfg.prim),
        .hyst_i   (cfg.hyst),
        .fall_i   (cfg.dir_fall),
        .fire_o   (p_fire),
        .beyond_o (p_beyond)
    );
    atq_level_det u_sec (
        .clock_i  (clock_i),
        .srst_i   (srst_i),
        .en_i     (sample_valid_i),
        .x_i      (x),
        .lvl_i    (cfg.sec),
        .hyst_i   (cfg.hyst),
        .fall_i   (!cfg.dir_fall),
        .fire_o   (s_fire),
        .beyond_o (s_beyond)
    );

    // pulse filter on the primary detector; pcnt measures the pulse length
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            run   <= 1'b0;
            pcnt  <= '0;
            p_evt <= 1'b0;
        end else begin
            p_evt <= 1'b0;
            case (cfg.pulse)
                atq_pkg::PULSE_DETECT, atq_pkg::PULSE_REJECT: begin
                    if (p_fire) begin
                        run  <= 1'b1;
                        pcnt <= '0;
                    end else if (run) begin
                        if (sample_valid_i && !p_beyond) begin
                            run <= 1'b0;
                            // detect: pass pulses no longer than the width
                            if (cfg.pulse == atq_pkg::PULSE_DETECT && pcnt <= cfg.pwidth)
                                p_evt <= 1'b1;
                        end else if (time_tick) begin
                            pcnt <= pcnt + 1'b1;
                            // reject: only a pulse outlasting the width gets through
                            if (cfg.pulse == atq_pkg::PULSE_REJECT && pcnt == cfg.pwidth)
                                p_evt <= 1'b1;
                        end
                    end
                end
                default: begin
                    run   <= 1'b0;
                    pcnt  <= '0;
                    p_evt <= p_fire;
                end
            endcase
        end
    end

    // mode select per channel type
    always_comb begin
        det_evt   = 1'b0;
        qual_mode = 1'b0;
        case (cfg.chan)
            atq_pkg::CHAN_MARKER: begin
                case (cfg.mark)
                    atq_pkg::MARK_RISE:  det_evt = sample_valid_i && pin_lvl[0] && !mark_prev;
                    atq_pkg::MARK_FALL:  det_evt = sample_valid_i && !pin_lvl[0] && mark_prev;
                    atq_pkg::MARK_QHIGH: det_evt = sample_valid_i && pin_lvl[0];
                    atq_pkg::MARK_QLOW:  det_evt = sample_valid_i && !pin_lvl[0];
                    default:             det_evt = 1'b0;
                endcase
            end
            default: begin
                case (cfg.mode)
                    atq_pkg::MODE_BASIC: det_evt = p_evt;
                    atq_pkg::MODE_DUAL:  det_evt = p_evt || s_fire;
                    atq_pkg::MODE_BASIC_QUAL: begin
                        det_evt   = p_evt && (cfg.chan != atq_pkg::CHAN_CALC);
                        qual_mode = 1'b1;
                    end
                    atq_pkg::MODE_DUAL_QUAL: begin
                        det_evt   = (p_evt || s_fire) && (cfg.chan != atq_pkg::CHAN_CALC);
                        qual_mode = 1'b1;
                    end
                    default: det_evt = 1'b0;
                endcase
            end
        endcase
    end

    // marker level at the previous sample
    always_ff @(posedge clock_i) begin
        if (srst_i)              mark_prev <= 1'b0;
        else if (sample_valid_i) mark_prev <= pin_lvl[0];
    end

    // qualifier gate and hold-off
    assign raw_evt = det_evt && (!qual_mode || pin_lvl[1])
                     && (hold_cnt == '0);

    // hold-off: reload on every final trigger, count down on the time base
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            hold_cnt <= '0;
        end else if (final_trig) begin
            hold_cnt <= cfg.hold;
        end else if (time_tick && hold_cnt != '0) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    // interval timer: spacing since the previous event, saturating
    assign win_end = {1'b0, cfg.tstart} + {1'b0, cfg.twidth};
    always_comb begin
        case (cfg.timer)
            atq_pkg::TIMER_LESS:    pass_evt = raw_evt && seen && itv_cnt < cfg.tstart;
            atq_pkg::TIMER_MORE:    pass_evt = raw_evt && seen && itv_cnt > cfg.tstart;
            atq_pkg::TIMER_BETWEEN: pass_evt = raw_evt && seen && itv_cnt >= cfg.tstart
                                               && {1'b0, itv_cnt} < win_end;
            atq_pkg::outside_range_mode:
                pass_evt = raw_evt && seen && !(itv_cnt >= cfg.tstart
                                               && {1'b0, itv_cnt} < win_end);
            default:                pass_evt = raw_evt;
        endcase
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            itv_cnt <= '0;
            seen    <= 1'b0;
        end else if (raw_evt) begin
            itv_cnt <= '0;
            seen    <= 1'b1;
        end else if (time_tick && itv_cnt != '1) begin
            itv_cnt <= itv_cnt + 1'b1;
        end
    end

    // event counter; a preset of zero behaves as one
    assign next_evt_cnt = evt_cnt + 1'b1;
    assign final_trig   = pass_evt && (next_evt_cnt == cfg.preset || cfg.preset == '0);
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            evt_cnt <= '0;
        end else if (final_trig) begin
            evt_cnt <= '0;
        end else if (pass_evt) begin
            evt_cnt <= next_evt_cnt;
        end
    end

    // registered trigger pulse
    always_ff @(posedge clock_i) begin
        if (srst_i) trig_o <= 1'b0;
        else        trig_o <= final_trig;
    end
endmodule : atq_trigger

/* File: atq_trigger_sva.sv */
// atq_trigger_sva: bus and trigger timing checks for atq_trigger.
// assumes it is bound to atq_trigger and sees only its ports.
`timescale 1ns/1ns
module atq_trigger_sva (
    // clock and reset
    input wire logic        clock_i,
    input wire logic        srst_i,
    // watched ports
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        sample_valid_i,
    input wire logic        trig_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // one low cycle per request, then wait again
    sequence s_ack; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_ack; (avs_read || avs_write) && avs_waitrequest |=> s_ack; endproperty
    a_ack: assert property (p_ack) else $error("waitrequest not low for one cycle");
    property p_idle; !(avs_read || avs_write) |=> avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("waitrequest low while idle");
    property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
    a_cause: assert property (p_cause) else $error("answer without request");
    property p_hold; !avs_read |=> $stable(avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("readdata moved without read");
    property p_stand; avs_read && avs_waitrequest |=> ##1 $stable(avs_readdata); endproperty
    a_stand: assert property (p_stand) else $error("readdata not standing");
    property p_hi; avs_readdata[31:24] == 8'h00; endproperty
    a_hi: assert property (p_hi) else $error("readdata upper bits set");
    property p_rst; $fell(srst_i) |-> !trig_o && avs_waitrequest && avs_readdata == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
    // a trigger traces back to a sample strobe except in pulse reject on external ticks; marker paths answer one edge after it, level paths two or three
    property p_src; trig_o |-> $past(sample_valid_i, 1) || $past(sample_valid_i, 2)
        || $past(sample_valid_i, 3); endproperty
    a_src: assert property (p_src) else $error("trigger without sample");
endmodule : atq_trigger_sva
bind atq_trigger atq_trigger_sva u_sva (.clock_i(clock_i), .srst_i(srst_i), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sample_valid_i(sample_valid_i), .trig_o(trig_o));

/* File: atq_sample_src.sv */
// atq_sample_src: front-end model handing samples to the detector.
// assumes one caller at a time; samples are spaced so triggers settle.
`timescale 1ns/1ns
module atq_sample_src (
    input  wire logic                     clock_i,
    output logic                          valid_o  = 1'b0,
    output logic signed [atq_pkg::SW-1:0] sample_o = 16'h0000
);
    // data inverts between strobes so a stale value never looks valid
    task automatic send(input logic signed [atq_pkg::SW-1:0] v);
        @(posedge clock_i);
        valid_o  <= 1'b1;
        sample_o <= v;
        @(posedge clock_i);
        valid_o  <= 1'b0;
        sample_o <= ~v;
        repeat (4) @(posedge clock_i);
    endtask : send
endmodule : atq_sample_src

/* File: atq_trigger_tb.sv */
// atq_trigger_tb: register and trigger-path checks for atq_trigger.
// assumes atq_sample_src feeds samples and the checker is bound in.
`timescale 1ns/1ns
module atq_trigger_tb;
    logic               clock_i = 1'b0;
    logic               srst_i = 1'b1;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic               qualifier_i = 1'b0;
    logic               marker_i = 1'b0;
    logic [5:0]         avs_address = 6'h00;
    logic [31:0]        avs_writedata = 32'h0;
    logic [31:0]        avs_readdata;
    logic [31:0]        q;
    logic               avs_waitrequest;
    logic               sv;
    logic               trig_o;
    logic signed [15:0] smp;
    int                 err_count = 0;
    int                 compares = 0;
    int                 ntrig = 0;
    int                 expn = 0;
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    atq_trigger uut (.clock_i(clock_i), .srst_i(srst_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .sample_valid_i(sv), .sample_i(smp), .marker_i(marker_i), .qualifier_i(qualifier_i),
        .ext_tick_i(1'b0), .trig_o(trig_o));
    atq_sample_src src (.clock_i(clock_i), .valid_o(sv), .sample_o(smp));
    // count trigger pulses
    always @(posedge clock_i) if (trig_o === 1'b1) ntrig++;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // hold the request until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clock_i);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        // only the watchdog ends a wait that never comes
        do begin
            @(posedge clock_i);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", e, q);
    endtask : rd
    task automatic xing(input logic signed [15:0] a, input logic signed [15:0] b, input int d);
        src.send(a);
        src.send(b);
        expn += d;
        chk("trig_count", expn, ntrig);
    endtask : xing
    task automatic end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20) @(posedge clock_i);
        srst_i <= 1'b0;
        rd(atq_pkg::OFS_CTRL, 32'h0);
        rd(atq_pkg::OFS_WIN, 32'h1);
        rd(atq_pkg::OFS_PRESET, 32'h1);
        rd(6'h2c, 32'h0);
        bus(1'b1, atq_pkg::OFS_PRIM, 32'h000a);
        bus(1'b1, atq_pkg::OFS_HYST, 32'h0002);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h0004);
        xing(7, 10, 0);
        xing(10, 11, 1);
        bus(1'b1, atq_pkg::OFS_HOLD, 32'h0003);
        xing(7, 11, 1);
        xing(7, 11, 0);
        xing(0, 0, 0);
        // zero hold-off before expiry check, so the reload leaves no count behind
        bus(1'b1, atq_pkg::OFS_HOLD, 32'h0);
        xing(7, 11, 1);
        bus(1'b1, atq_pkg::OFS_PRESET, 32'h2);
        for (int i = 0; i < 4; i++) xing(7, 11, i % 2);
        rd(atq_pkg::OFS_STATUS, 32'h20000);
        bus(1'b1, atq_pkg::OFS_PRESET, 32'h1);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h0024);
        xing(13, 9, 1);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h000c);
        xing(7, 11, 0);
        qualifier_i <= 1'b1;
        xing(7, 11, 1);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h000f);
        xing(7, 11, 0);
        // marker edges: the second sample sees the synchronised level
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h1001);
        marker_i <= 1'b1;
        xing(0, 0, 1);
        xing(0, 0, 0);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h2001);
        marker_i <= 1'b0;
        xing(0, 0, 1);
        // less mode: spacing 4 refused, spacing 2 passes
        bus(1'b1, atq_pkg::OFS_TSTART, 32'h3);
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h0204);
        xing(0, 0, 0);
        xing(7, 11, 0);
        xing(7, 11, 1);
        // slope over one sample: differences 0 then 11, later 8 and 5
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h0044);
        xing(11, 22, 1);
        xing(30, 35, 0);
        // dual: secondary at zero answers falling while primary is rising
        bus(1'b1, atq_pkg::OFS_CTRL, 32'h0008);
        xing(5, -1, 1);
        end_of_test();
    end
    // cut a hang short
    initial begin
        repeat (5000) @(posedge clock_i);
        err_count++;
        end_of_test();
    end
endmodule : atq_trigger_tb
